// ### inc/vcr_pkg.sv
package vcr_pkg;
   // i/o port addresses
   localparam logic [9:0] ADR_CRTC_INDEX  = 10'h3D4;
   localparam logic [9:0] ADR_CRTC_DATA   = 10'h3D5;
   localparam logic [9:0] ADR_MODE_SEL    = 10'h3D8;
   localparam logic [9:0] ADR_COLOUR_SEL  = 10'h3D9;
   localparam logic [9:0] ADR_ARRAY_INDEX = 10'h3DA;
   localparam logic [9:0] ADR_PEN_CLEAR   = 10'h3DB;
   localparam logic [9:0] ADR_PEN_PRESET  = 10'h3DC;
   localparam logic [9:0] ADR_EXT_PAGE    = 10'h3DD;
   localparam logic [9:0] ADR_ARRAY_DATA  = 10'h3DE;
   // video-array register indices
   localparam logic [4:0] IDX_PAL_MASK    = 5'h01;
   localparam logic [4:0] IDX_BORDER      = 5'h02;
   localparam logic [4:0] IDX_EXT_MODE    = 5'h03;
   localparam logic [4:0] IDX_PAL_BASE    = 5'h10;
   // mode select bit positions
   localparam int MODE_HIRES_TEXT = 0;
   localparam int MODE_GRAPHICS   = 1;
   localparam int MODE_MONO       = 2;
   localparam int MODE_VID_EN     = 3;
   localparam int MODE_HIRES_GFX  = 4;
   localparam int MODE_BLINK      = 5;
   // extended page register bit positions
   localparam int PAGE_EXT_ADDR   = 0;
   localparam int PAGE_DISP_LO    = 2;
   localparam int PAGE_CPU_LO     = 4;
   localparam int PAGE_BIG_RAM    = 7;
   // status read bit positions
   localparam int STAT_DISP_OFF   = 0;
   localparam int STAT_PEN_SET    = 1;
   localparam int STAT_PEN_SW     = 2;
   localparam int STAT_VRETRACE   = 3;
   // reset values and palette entry count
   localparam logic [7:0] RST_BYTE    = 8'h00;
   localparam logic [3:0] RST_PAL_MASK = 4'hF;
   localparam int NUM_PAL = 16;

   // decoded display mode for the video pipeline
   typedef struct packed {
      logic       cols80;     // 80x25 text when set, 40x25 when clear
      logic       graphics;   // 320x200 graphics
      logic       mono;       // black and white output
      logic       video_on;   // video signal gated on
      logic       hires_gfx;  // 640x200 b&w graphics
      logic       blink;      // character blink
   } vcr_mode_s;

   // extended page fields
   typedef struct packed {
      logic       ext_addr;   // extended addressing mode
      logic [1:0] disp_page;  // display page address
      logic [1:0] cpu_page;   // processor page a17/a18
      logic       big_ram;    // 256k video memory when set, 64k when clear
   } vcr_page_s;

   // host i/o bus request
   typedef struct packed {
      logic       wr;         // one-cycle write strobe
      logic       rd;         // one-cycle read strobe
      logic [9:0] addr;       // port address
      logic [7:0] wdata;      // write data
   } vcr_io_s;
endpackage

// ### verilog/vcr_array_file.sv
`timescale 1ns/100ps
`default_nettype none
// indexed video-array register file behind the index and data ports
module vcr_array_file
   import vcr_pkg::*;
#(
   parameter int NPAL = NUM_PAL
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   // host side
   input  wire logic        idx_we,
   input  wire logic        dat_we,
   input  wire logic [7:0]  wdata,
   // register contents
   output logic [3:0]       pal_mask,
   output logic [5:0]       border,
   output logic [5:0]       ext_mode,
   output logic [NPAL*4-1:0] palette
);
   // palette indexing below serves exactly sixteen entries
   if (NPAL != NUM_PAL) begin : g_bad_npal
      $error("vcr_array_file: palette must have 16 entries");
   end

   // all state in one struct
   typedef struct packed {
      logic [4:0]       index;    // persistent array index
      logic [3:0]       pal_mask;
      logic [5:0]       border;
      logic [5:0]       ext_mode;
      logic [NPAL*4-1:0] pal;
   } vcr_af_s;

   vcr_af_s st;       // registered state
   vcr_af_s next_st;  // next state

   // next-state logic
   always_comb begin
      next_st = st;
      // index holds until rewritten
      if (idx_we) begin
         next_st.index = wdata[4:0];
      end
      // data write lands in the latest indexed register
      if (dat_we) begin
         case (st.index)
            IDX_PAL_MASK: next_st.pal_mask = wdata[3:0];
            IDX_BORDER:   next_st.border   = {1'b0, wdata[4:0]}; // bit 5 reserved zero
            IDX_EXT_MODE: next_st.ext_mode = {wdata[5:2], 1'b0, wdata[0]}; // bit 1 reserved zero
            default: begin
               // upper half of index space holds the palette
               if (st.index[4]) begin
                  next_st.pal[st.index[3:0]*4 +: 4] = wdata[3:0];
               end
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '{index: 5'h00, pal_mask: RST_PAL_MASK, border: 6'h00, ext_mode: 6'h00, pal: '0};
      end else if (ce) begin
         st <= next_st;
      end
   end

   // register contents out
   assign pal_mask = st.pal_mask;
   assign border   = st.border;
   assign ext_mode = st.ext_mode;
   assign palette  = st.pal;
endmodule
`default_nettype wire

// ### verilog/vcr_regs.sv
`timescale 1ns/100ps
`default_nettype none
module vcr_regs
   import vcr_pkg::*;
(
   // clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST_B,
   input  wire logic        CE,
   // host i/o bus
   input  wire vcr_io_s     IO,
   output logic [7:0]       RDATA,
   output logic             RD_HIT,
   // crtc register port pass-through
   output logic             CRTC_IDX_WE,
   output logic             CRTC_DAT_WE,
   output logic             CRTC_DAT_RE,
   input  wire logic [7:0]  CRTC_RDATA,
   // display timing status from the raster logic
   input  wire logic        DISP_INACTIVE,
   input  wire logic        VRETRACE,
   // decoded controls
   output vcr_mode_s        MODE,
   output logic [5:0]       COLOUR_SEL,
   output vcr_page_s        PAGE,
   output logic             VIDEO_GATE,
   output logic [3:0]       PAL_MASK,
   output logic [5:0]       BORDER,
   output logic [5:0]       EXT_MODE,
   output logic [63:0]      PALETTE
);
   // all state in one struct
   typedef struct packed {
      logic [7:0] mode;       // mode select
      logic [7:0] colour;     // colour select
      logic [7:0] page;       // extended page
      logic [1:0] dinact_s;   // synchroniser, display inactive
      logic [1:0] vretr_s;    // synchroniser, vertical retrace
      logic [7:0] rdata;      // read data register
      logic       rd_hit;     // read answered
   } vcr_top_s;

   vcr_top_s st;       // registered state
   vcr_top_s next_st;  // next state

   // address match helper
   function automatic logic hit(input logic [9:0] a, input logic [9:0] ref_a);
      return a == ref_a;
   endfunction

   logic wr_idx;   // array index write
   logic wr_dat;   // array data write
   logic [7:0] status; // status byte

   // write strobes and crtc data read strobe decoded
   always_comb begin
      wr_idx      = IO.wr && hit(IO.addr, ADR_ARRAY_INDEX);
      wr_dat      = IO.wr && hit(IO.addr, ADR_ARRAY_DATA);
      CRTC_IDX_WE = IO.wr && hit(IO.addr, ADR_CRTC_INDEX);
      CRTC_DAT_WE = IO.wr && hit(IO.addr, ADR_CRTC_DATA);
      CRTC_DAT_RE = IO.rd && hit(IO.addr, ADR_CRTC_DATA);
   end

   // status byte: pen bits always zero, no pen fitted
   always_comb begin
      status = 8'h00;
      status[STAT_DISP_OFF] = st.dinact_s[1];
      status[STAT_VRETRACE] = st.vretr_s[1];
   end

   // next-state logic
   always_comb begin
      next_st = st;
      next_st.dinact_s = {st.dinact_s[0], DISP_INACTIVE};
      next_st.vretr_s  = {st.vretr_s[0], VRETRACE};
      next_st.rd_hit   = 1'b0;
      next_st.rdata    = RST_BYTE;
      // register writes
      if (IO.wr) begin
         case (IO.addr)
            ADR_MODE_SEL:   next_st.mode   = {2'b00, IO.wdata[5:0]};
            ADR_COLOUR_SEL: next_st.colour = {2'b00, IO.wdata[5:0]};
            ADR_EXT_PAGE:   next_st.page   = {IO.wdata[7:2], 1'b0, IO.wdata[0]};
            ADR_PEN_CLEAR, ADR_PEN_PRESET: begin
               next_st.page = st.page;
            end
            default: begin
               next_st.page = st.page;
            end
         endcase
      end
      // reads: status and crtc data answer, everything else is write only
      if (IO.rd) begin
         case (IO.addr)
            ADR_ARRAY_INDEX: begin
               next_st.rdata  = status;
               next_st.rd_hit = 1'b1;
            end
            ADR_CRTC_DATA: begin
               next_st.rdata  = CRTC_RDATA;
               next_st.rd_hit = 1'b1;
            end
            default: begin
               next_st.rd_hit = 1'b0;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         st <= '0;
      end else if (CE) begin
         st <= next_st;
      end
   end

   // video-array file
   vcr_array_file #(
      .NPAL (NUM_PAL)
   ) u_array (
      .clk      (CORE_CLK),
      .rst_b    (RST_B),
      .ce       (CE),
      .idx_we   (wr_idx),
      .dat_we   (wr_dat),
      .wdata    (IO.wdata),
      .pal_mask (PAL_MASK),
      .border   (BORDER),
      .ext_mode (EXT_MODE),
      .palette  (PALETTE)
   );

   // decoded outputs
   // one driver for the whole mode struct
   assign MODE = '{
      cols80:    st.mode[MODE_HIRES_TEXT],
      graphics:  st.mode[MODE_GRAPHICS],
      mono:      st.mode[MODE_MONO],
      video_on:  st.mode[MODE_VID_EN],
      hires_gfx: st.mode[MODE_HIRES_GFX],
      blink:     st.mode[MODE_BLINK]
   };
   assign VIDEO_GATE     = st.mode[MODE_VID_EN];
   assign COLOUR_SEL     = st.colour[5:0];
   // one driver for the whole page struct
   assign PAGE = '{
      ext_addr:  st.page[PAGE_EXT_ADDR],
      disp_page: st.page[PAGE_DISP_LO +: 2],
      cpu_page:  st.page[PAGE_CPU_LO +: 2],
      big_ram:   st.page[PAGE_BIG_RAM]
   };
   assign RDATA          = st.rdata;
   assign RD_HIT         = st.rd_hit;
endmodule
`default_nettype wire

// ### test/vcr_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none
// port checks on the host register set
module vcr_regs_sva
   import vcr_pkg::*;
(
   input wire logic       CORE_CLK,
   input wire logic       RST_B,
   input wire logic       CE,
   input wire vcr_io_s    IO,
   input wire logic [7:0] RDATA,
   input wire logic       RD_HIT,
   input wire vcr_mode_s  MODE,
   input wire logic       VIDEO_GATE,
   input wire vcr_page_s  PAGE
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   logic       mw;  // mode write taken
   logic       pw;  // page write taken
   logic [7:0] d;   // write data alias
   assign mw = CE && IO.wr && IO.addr == ADR_MODE_SEL;
   assign pw = CE && IO.wr && IO.addr == ADR_EXT_PAGE;
   assign d = IO.wdata;
   chk_mode_text: assert property (
      mw |=> MODE.cols80 == $past(d[0]) && MODE.graphics == $past(d[1])) else $error("text mode bits wrong");
   chk_mode_mono: assert property (
      mw |=> MODE.mono == $past(d[2])) else $error("mono bit wrong");
   chk_gate_set: assert property (
      mw |=> VIDEO_GATE == $past(d[3])) else $error("video gate wrong");
   chk_gate_hold: assert property (
      !mw |=> $stable(VIDEO_GATE)) else $error("video gate moved");
   chk_mode_gfx: assert property (
      mw |=> MODE.hires_gfx == $past(d[4]) && MODE.blink == $past(d[5])) else $error("gfx or blink wrong");
   chk_status_read: assert property (
      CE && IO.rd && IO.addr == ADR_ARRAY_INDEX |=> RD_HIT && RDATA[7:4] == 4'h0 && RDATA[2:1] == 2'h0)
      else $error("status read wrong");
   chk_pen_quiet: assert property (
      CE && IO.rd && (IO.addr == ADR_PEN_CLEAR || IO.addr == ADR_PEN_PRESET) |=> !RD_HIT && RDATA == 8'h00)
      else $error("pen port answered");
   chk_page_write: assert property (
      pw |=> PAGE == {$past(d[0]), $past(d[3:2]), $past(d[5:4]), $past(d[7])}) else $error("page fields wrong");
endmodule
bind vcr_regs vcr_regs_sva chk (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .CE(CE), .IO(IO), .RDATA(RDATA),
   .RD_HIT(RD_HIT), .MODE(MODE), .VIDEO_GATE(VIDEO_GATE), .PAGE(PAGE));
`default_nettype wire

// ### test/vcr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host processor issuing single i/o cycles
module vcr_host_model
   import vcr_pkg::*;
(
   input wire logic       clk,
   input wire logic [7:0] rdata,
   input wire logic       rd_hit,
   output var vcr_io_s    io
);
   initial io = '0;
   // strobe for one edge, answer sampled just after it
   task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] v, output logic [7:0] q,
                       output logic h);
      @(posedge clk);
      io <= '{w, !w, a, v};
      @(posedge clk);
      io <= '{1'b0, 1'b0, ~a, ~v};
      #1;
      q = rdata;
      h = rd_hit;
   endtask
endmodule
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import vcr_pkg::*;
   logic core_clk = 0, rst_b = 0, dinact = 0, vret = 0, rd_hit, gate;
   logic ce = 1, crtc_iw, crtc_dw, crtc_dr;
   int n_iw = 0, n_dw = 0, n_dr = 0;
   logic [7:0] rdata;
   logic [5:0] colour, border, ext_mode;
   logic [3:0] pal_mask;
   logic [63:0] palette;
   vcr_io_s io;
   vcr_mode_s mode;
   vcr_page_s page;
   int mismatches = 0, cmp_count = 0, cycles = 0;
   always #10 core_clk = ~core_clk;
   vcr_host_model host (.clk(core_clk), .rdata(rdata), .rd_hit(rd_hit), .io(io));
   vcr_regs dut (.CORE_CLK(core_clk), .RST_B(rst_b), .CE(ce), .IO(io), .RDATA(rdata), .RD_HIT(rd_hit),
      .CRTC_IDX_WE(crtc_iw), .CRTC_DAT_WE(crtc_dw), .CRTC_DAT_RE(crtc_dr), .CRTC_RDATA(8'hA5), .DISP_INACTIVE(dinact),
      .VRETRACE(vret), .MODE(mode), .COLOUR_SEL(colour), .PAGE(page), .VIDEO_GATE(gate),
      .PAL_MASK(pal_mask), .BORDER(border), .EXT_MODE(ext_mode), .PALETTE(palette));
   // count crtc pass-through strobes as the design takes them
   always @(posedge core_clk) begin
      n_iw <= n_iw + crtc_iw;
      n_dw <= n_dw + crtc_dw;
      n_dr <= n_dr + crtc_dr;
   end
   // compare and count
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      logic [7:0] q;
      logic h;
      host.xfer(1'b1, a, v, q, h);
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] exp, input logic hit);
      logic [7:0] q;
      logic h;
      host.xfer(1'b0, a, 8'h00, q, h);
      chk(h, hit);
      chk(q, exp);
   endtask
   // each mode bit alone, and mode port not readable
   task automatic t_mode;
      for (int i = 0; i < 6; i++) begin
         wr(ADR_MODE_SEL, 8'h01 << i);
         chk(mode, 6'h20 >> i);
         chk(gate, i == 3);
      end
      rd(ADR_MODE_SEL, 8'h00, 1'b0);
      $display("mode test done");
   endtask
   // index persists over several data writes
   task automatic t_array;
      chk(pal_mask, 4'hF);
      wr(ADR_ARRAY_INDEX, 8'h10);
      wr(ADR_ARRAY_DATA, 8'h05);
      wr(ADR_ARRAY_DATA, 8'h06);
      chk(palette, 64'h6);
      wr(ADR_ARRAY_INDEX, 8'h1F);
      wr(ADR_ARRAY_DATA, 8'h0C);
      chk(palette, 64'hC000_0000_0000_0006);
      wr(ADR_ARRAY_INDEX, 8'h01);
      wr(ADR_ARRAY_DATA, 8'h03);
      wr(ADR_ARRAY_INDEX, 8'h02);
      wr(ADR_ARRAY_DATA, 8'h0F);
      wr(ADR_ARRAY_INDEX, 8'h03);
      wr(ADR_ARRAY_DATA, 8'h3D);
      chk({pal_mask, border, ext_mode}, {4'h3, 6'h0F, 6'h3D});
      $display("array test done");
   endtask
   // status levels reach the index port read
   task automatic t_status;
      @(posedge core_clk);
      dinact <= 1'b1;
      vret <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(ADR_ARRAY_INDEX, 8'h09, 1'b1);
      @(posedge core_clk);
      dinact <= 1'b0;
      repeat (4) @(posedge core_clk);
      rd(ADR_ARRAY_INDEX, 8'h08, 1'b1);
      $display("status test done");
   endtask
   // clock enable low freezes the mode register and video gate
   task automatic t_freeze;
      @(posedge core_clk);
      ce <= 1'b0;
      wr(ADR_MODE_SEL, 8'h3F);
      chk(mode, 6'h01);
      chk(gate, 1'b0);
      @(posedge core_clk);
      ce <= 1'b1;
      $display("freeze test done");
   endtask
   // colour select and crtc port pass-through
   task automatic t_crtc_colour;
      wr(ADR_COLOUR_SEL, 8'hFF);
      chk(colour, 6'h3F);
      wr(ADR_CRTC_INDEX, 8'h0E);
      wr(ADR_CRTC_DATA, 8'h12);
      rd(ADR_CRTC_DATA, 8'hA5, 1'b1);
      chk({n_iw[7:0], n_dw[7:0], n_dr[7:0]}, 24'h010101);
      $display("colour and crtc test done");
   endtask
   // page fields, then pen ports leave all alone
   task automatic t_page_pen;
      wr(ADR_EXT_PAGE, 8'h95);
      chk(page, 6'h2B);
      wr(ADR_PEN_CLEAR, 8'hFF);
      wr(ADR_PEN_PRESET, 8'hFF);
      chk({mode, page}, {6'h01, 6'h2B});
      rd(ADR_PEN_CLEAR, 8'h00, 1'b0);
      $display("page and pen test done");
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         end_of_test;
      end
   end
   initial begin
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      t_mode;
      t_freeze;
      t_array;
      t_status;
      t_page_pen;
      t_crtc_colour;
      end_of_test;
   end
endmodule
`default_nettype wire
